//--- tsc_pkg.sv
`default_nettype none
package tsc_pkg;
	// --------------------------------------------------------------
	// Bus geometry and responses
	// --------------------------------------------------------------
	localparam int         ADDR_W       = 8;
	localparam int         DATA_W       = 32;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;
	localparam logic [1:0] RESP_DECERR  = 2'h3;
	// --------------------------------------------------------------
	// Register offsets
	// --------------------------------------------------------------
	localparam logic [7:0] OFS_TIMER1   = 8'h00;
	localparam logic [7:0] OFS_TIMER2   = 8'h04;
	localparam logic [7:0] OFS_ACT_HMS  = 8'h08;
	localparam logic [7:0] OFS_ACT_DAY  = 8'h0C;
	localparam logic [7:0] OFS_CAL_TIME = 8'h10;
	localparam logic [7:0] OFS_CAL_DATE = 8'h14;
	localparam logic [7:0] OFS_STATUS   = 8'h18;
	// --------------------------------------------------------------
	// Field positions and implemented bits
	// --------------------------------------------------------------
	localparam int HOUR_LSB     = 16;
	localparam int MIN_LSB      = 8;
	localparam int SEC_LSB      = 0;
	localparam int DAY_LSB      = 0;
	localparam int WEEKEN_LSB   = 8;
	localparam int WDAY_LSB     = 8;
	localparam int MONTH_LSB    = 16;
	localparam int YEAR_LSB     = 24;
	localparam int STAT_LS_LSB  = 8;
	localparam int STAT_LED_LSB = 16;
	localparam logic [31:0] HMS_MASK     = 32'h001F_3F3F;
	localparam logic [31:0] ACT_DAY_MASK = 32'h0000_7F1F;
	localparam logic [31:0] DATE_MASK    = 32'h030F_071F;
	// --------------------------------------------------------------
	// Values after reset
	// --------------------------------------------------------------
	localparam logic [31:0] TIMER1_RST   = 32'h0008_0000;
	localparam logic [31:0] TIMER2_RST   = 32'h0011_0000;
	localparam logic [31:0] ACT_HMS_RST  = 32'h000C_0000;
	localparam logic [31:0] ACT_DAY_RST  = 32'h0000_1F01;
	localparam logic [31:0] CAL_DATE_RST = 32'h0001_0001;
	// --------------------------------------------------------------
	// Value limits
	// --------------------------------------------------------------
	localparam logic [4:0] MAX_HOUR  = 5'h17;
	localparam logic [5:0] MAX_MIN   = 6'h3B;
	localparam logic [5:0] MAX_SEC   = 6'h3B;
	localparam logic [4:0] MIN_DAY   = 5'h01;
	localparam logic [4:0] MAX_DAY   = 5'h1F;
	localparam logic [2:0] MAX_WDAY  = 3'h6;
	localparam logic [3:0] MIN_MONTH = 4'h1;
	localparam logic [3:0] MAX_MONTH = 4'hC;
	// --------------------------------------------------------------
	// Time output order and timebase
	// --------------------------------------------------------------
	localparam int TO_TIMER1  = 0;
	localparam int TO_TIMER2  = 1;
	localparam int TO_WEEKDAY = 2;
	localparam int TO_DAY     = 3;
	localparam int TO_HOUR    = 4;
	localparam int TO_MINUTE  = 5;
	localparam int TO_SECOND  = 6;
	localparam int CLK_PERIOD_NS    = 10;
	localparam int SECOND_NS        = 1000000000;
	localparam int TICK_CYCLES_DFLT = SECOND_NS / CLK_PERIOD_NS;
endpackage
`default_nettype wire

//--- tsc_top.sv
// Function
// - Seven time outputs in fixed order
// - Daily timer true from setpoint to midnight
// - Timer hour 0-23, defaults 8 and 17
// - Timer minute 0-59, default 0
// - Timer second 0-59, default 0
// - Active day 1-31, default 1
// - Active day output true whole matching day
// - Active hour whole hour, 0-23, default 12
// - Active minute whole minute, default 0
// - Active second only that second, default 0
// - Weekday output true whole selected weekday
// - Seven weekday enables, Monday-Friday on
// - Five load-share flags sent to peers
// - Eight LED flags drive front LEDs
`timescale 1ns/100ps
`default_nettype none
module tsc_top #(
	parameter int TICK_CYCLES = tsc_pkg::TICK_CYCLES_DFLT
) (
	input  wire logic        clk,            // 100 MHz clock
	input  wire logic        rst_n,          // Async reset, active low
	input  wire logic [7:0]  s_axi_awaddr,   // Write address
	input  wire logic        s_axi_awvalid,  // Write address valid
	output var  logic        s_axi_awready,  // Write address ready
	input  wire logic [31:0] s_axi_wdata,    // Write data
	input  wire logic [3:0]  s_axi_wstrb,    // Write byte strobes
	input  wire logic        s_axi_wvalid,   // Write data valid
	output var  logic        s_axi_wready,   // Write data ready
	output var  logic [1:0]  s_axi_bresp,    // Write response
	output var  logic        s_axi_bvalid,   // Write response valid
	input  wire logic        s_axi_bready,   // Write response ready
	input  wire logic [7:0]  s_axi_araddr,   // Read address
	input  wire logic        s_axi_arvalid,  // Read address valid
	output var  logic        s_axi_arready,  // Read address ready
	output var  logic [31:0] s_axi_rdata,    // Read data
	output var  logic [1:0]  s_axi_rresp,    // Read response
	output var  logic        s_axi_rvalid,   // Read data valid
	input  wire logic        s_axi_rready,   // Read data ready
	input  wire logic [4:0]  lsFlagIn,       // Load-share flag equation results
	input  wire logic [7:0]  ledFlagIn,      // LED flag equation results
	output var  logic [6:0]  timeOut,        // Time command outputs
	output var  logic [4:0]  lsFlagOut,      // Load-share flags toward peers
	output var  logic [7:0]  ledOut          // Front-panel LED drive
);
	// --------------------------------------------------------------
	// Storage
	// --------------------------------------------------------------
	logic [31:0] timer1Word;
	logic [31:0] timer2Word;
	logic [31:0] actHmsWord;
	logic [31:0] actDayWord;
	logic [5:0]  calSec;
	logic [5:0]  calMin;
	logic [4:0]  calHour;
	logic [4:0]  calDay;
	logic [2:0]  calWday;
	logic [3:0]  calMonth;
	logic [1:0]  calYear;
	logic [26:0] divCnt;
	logic        evalPend;
	logic [7:0]  awAddr;
	logic        awHeld;
	logic [31:0] wData;
	logic [3:0]  wStrb;
	logic        wHeld;

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	function automatic logic [4:0] monthLen(input logic [3:0] m, input logic [1:0] y);
		logic [4:0] n;
		n = 5'h1F;
		if (m == 4'h2)
			n = (y == 2'h0) ? 5'h1D : 5'h1C;
		else if (m == 4'h4 || m == 4'h6 || m == 4'h9 || m == 4'hB)
			n = 5'h1E;
		return n;
	endfunction

	function automatic logic hmsOk(input logic [31:0] w);
		return (w[tsc_pkg::HOUR_LSB +: 5] <= tsc_pkg::MAX_HOUR)
			&& (w[tsc_pkg::MIN_LSB +: 6] <= tsc_pkg::MAX_MIN)
			&& (w[tsc_pkg::SEC_LSB +: 6] <= tsc_pkg::MAX_SEC);
	endfunction

	function automatic logic [31:0] readWord(input logic [7:0] a);
		logic [7:0]  wa;
		logic [31:0] r;
		wa = {a[7:2], 2'h0};
		r = 32'h0000_0000;
		if (wa == tsc_pkg::OFS_TIMER1)
			r = timer1Word;
		else if (wa == tsc_pkg::OFS_TIMER2)
			r = timer2Word;
		else if (wa == tsc_pkg::OFS_ACT_HMS)
			r = actHmsWord;
		else if (wa == tsc_pkg::OFS_ACT_DAY)
			r = actDayWord;
		else if (wa == tsc_pkg::OFS_CAL_TIME)
			r = {11'h000, calHour, 2'h0, calMin, 2'h0, calSec};
		else if (wa == tsc_pkg::OFS_CAL_DATE)
			r = {6'h00, calYear, 4'h0, calMonth, 5'h00, calWday, 3'h0, calDay};
		else if (wa == tsc_pkg::OFS_STATUS)
			r = {8'h00, ledOut, 3'h0, lsFlagOut, 1'h0, timeOut};
		return r;
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		return {a[7:2], 2'h0} <= tsc_pkg::OFS_STATUS;
	endfunction

	// --------------------------------------------------------------
	// Write decode
	// --------------------------------------------------------------
	wire         doWrite   = awHeld && wHeld && !s_axi_bvalid;
	wire  [7:0]  wrWa      = {awAddr[7:2], 2'h0};
	wire  [31:0] byteMask  = {{8{wStrb[3]}}, {8{wStrb[2]}}, {8{wStrb[1]}}, {8{wStrb[0]}}};
	logic [31:0] merged;
	always_comb merged = (readWord(awAddr) & ~byteMask) | (wData & byteMask);
	wire  [4:0]  mDay      = merged[tsc_pkg::DAY_LSB +: 5];
	wire  [3:0]  mMonth    = merged[tsc_pkg::MONTH_LSB +: 4];
	wire  [1:0]  mYear     = merged[tsc_pkg::YEAR_LSB +: 2];
	wire         actDayOk  = (mDay >= tsc_pkg::MIN_DAY) && (mDay <= tsc_pkg::MAX_DAY);
	wire         dateOk    = (mMonth >= tsc_pkg::MIN_MONTH) && (mMonth <= tsc_pkg::MAX_MONTH)
		&& (mDay >= tsc_pkg::MIN_DAY) && (mDay <= monthLen(mMonth, mYear))
		&& (merged[tsc_pkg::WDAY_LSB +: 3] <= tsc_pkg::MAX_WDAY);
	wire         isHmsReg  = (wrWa == tsc_pkg::OFS_TIMER1) || (wrWa == tsc_pkg::OFS_TIMER2)
		|| (wrWa == tsc_pkg::OFS_ACT_HMS) || (wrWa == tsc_pkg::OFS_CAL_TIME);
	// Out-of-range values are refused whole so no field is left half-updated
	wire         wrValid   = isHmsReg ? hmsOk(merged)
		: (wrWa == tsc_pkg::OFS_ACT_DAY) ? actDayOk
		: (wrWa == tsc_pkg::OFS_CAL_DATE) ? dateOk : 1'b1;
	wire         wrOk      = doWrite && mapped(awAddr) && wrValid;
	wire         ldTime    = wrOk && (wrWa == tsc_pkg::OFS_CAL_TIME);
	wire         ldDate    = wrOk && (wrWa == tsc_pkg::OFS_CAL_DATE);
	wire  [1:0]  wrResp    = !mapped(awAddr) ? tsc_pkg::RESP_DECERR
		: wrValid ? tsc_pkg::RESP_OKAY : tsc_pkg::RESP_SLVERR;
	wire         awHs      = s_axi_awvalid && s_axi_awready;
	wire         wHs       = s_axi_wvalid && s_axi_wready;
	wire         arHs      = s_axi_arvalid && s_axi_arready;
	wire         next_awHeld = doWrite ? 1'b0 : (awHeld | awHs);
	wire         next_wHeld  = doWrite ? 1'b0 : (wHeld | wHs);
	wire         next_rvalid = arHs ? 1'b1 : ((s_axi_rvalid && s_axi_rready) ? 1'b0 : s_axi_rvalid);

	// --------------------------------------------------------------
	// AXI4-Lite slave
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			awAddr <= 8'h00;
			awHeld <= 1'b0;
			wData  <= 32'h0000_0000;
			wStrb  <= 4'h0;
			wHeld  <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= tsc_pkg::RESP_OKAY;
		end
		else
		begin
			if (awHs)
				awAddr <= s_axi_awaddr;
			if (wHs)
			begin
				wData <= s_axi_wdata;
				wStrb <= s_axi_wstrb;
			end
			awHeld <= next_awHeld;
			wHeld  <= next_wHeld;
			s_axi_awready <= !next_awHeld;
			s_axi_wready  <= !next_wHeld;
			if (doWrite)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wrResp;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= tsc_pkg::RESP_OKAY;
		end
		else
		begin
			s_axi_rvalid  <= next_rvalid;
			s_axi_arready <= !next_rvalid;
			if (arHs)
			begin
				s_axi_rdata <= readWord(s_axi_araddr);
				s_axi_rresp <= mapped(s_axi_araddr) ? tsc_pkg::RESP_OKAY : tsc_pkg::RESP_DECERR;
			end
		end
	end

	// --------------------------------------------------------------
	// Setpoint registers
	// --------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			timer1Word <= tsc_pkg::TIMER1_RST;
			timer2Word <= tsc_pkg::TIMER2_RST;
			actHmsWord <= tsc_pkg::ACT_HMS_RST;
			actDayWord <= tsc_pkg::ACT_DAY_RST;
		end
		else if (wrOk)
		begin
			if (wrWa == tsc_pkg::OFS_TIMER1)
				timer1Word <= merged & tsc_pkg::HMS_MASK;
			if (wrWa == tsc_pkg::OFS_TIMER2)
				timer2Word <= merged & tsc_pkg::HMS_MASK;
			if (wrWa == tsc_pkg::OFS_ACT_HMS)
				actHmsWord <= merged & tsc_pkg::HMS_MASK;
			if (wrWa == tsc_pkg::OFS_ACT_DAY)
				actDayWord <= merged & tsc_pkg::ACT_DAY_MASK;
		end
	end

	// --------------------------------------------------------------
	// One-second timebase and calendar
	// --------------------------------------------------------------
	wire       tick    = (divCnt == 27'(TICK_CYCLES - 1));
	wire       secWrap = (calSec == tsc_pkg::MAX_SEC);
	wire       minWrap = secWrap && (calMin == tsc_pkg::MAX_MIN);
	wire       hrWrap  = minWrap && (calHour == tsc_pkg::MAX_HOUR);
	wire       dayWrap = hrWrap && (calDay == monthLen(calMonth, calYear));
	wire       monWrap = dayWrap && (calMonth == tsc_pkg::MAX_MONTH);

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			divCnt <= 27'h0000000;
		else if (tick || ldTime)
			divCnt <= 27'h0000000;
		else
			divCnt <= divCnt + 27'h0000001;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			calSec   <= 6'h00;
			calMin   <= 6'h00;
			calHour  <= 5'h00;
			calDay   <= tsc_pkg::CAL_DATE_RST[tsc_pkg::DAY_LSB +: 5];
			calWday  <= tsc_pkg::CAL_DATE_RST[tsc_pkg::WDAY_LSB +: 3];
			calMonth <= tsc_pkg::CAL_DATE_RST[tsc_pkg::MONTH_LSB +: 4];
			calYear  <= tsc_pkg::CAL_DATE_RST[tsc_pkg::YEAR_LSB +: 2];
		end
		else if (ldTime)
		begin
			calSec  <= merged[tsc_pkg::SEC_LSB +: 6];
			calMin  <= merged[tsc_pkg::MIN_LSB +: 6];
			calHour <= merged[tsc_pkg::HOUR_LSB +: 5];
		end
		else if (ldDate)
		begin
			calDay   <= mDay;
			calWday  <= merged[tsc_pkg::WDAY_LSB +: 3];
			calMonth <= mMonth;
			calYear  <= mYear;
		end
		else if (tick)
		begin
			calSec <= secWrap ? 6'h00 : calSec + 6'h01;
			if (secWrap)
				calMin <= minWrap ? 6'h00 : calMin + 6'h01;
			if (minWrap)
				calHour <= hrWrap ? 5'h00 : calHour + 5'h01;
			if (hrWrap)
			begin
				calWday <= (calWday == tsc_pkg::MAX_WDAY) ? 3'h0 : calWday + 3'h1;
				calDay  <= dayWrap ? tsc_pkg::MIN_DAY : calDay + 5'h01;
			end
			if (dayWrap)
				calMonth <= monWrap ? tsc_pkg::MIN_MONTH : calMonth + 4'h1;
			if (monWrap)
				calYear <= calYear + 2'h1;
		end
	end

	// --------------------------------------------------------------
	// Setpoint comparison
	// --------------------------------------------------------------
	// Settings are read live, but outputs only move at an evaluation,
	// so a write takes effect at the next one and unaffected outputs hold
	wire [16:0] nowHms  = {calHour, calMin, calSec};
	wire [16:0] t1Hms   = {timer1Word[tsc_pkg::HOUR_LSB +: 5], timer1Word[tsc_pkg::MIN_LSB +: 6],
		timer1Word[tsc_pkg::SEC_LSB +: 6]};
	wire [16:0] t2Hms   = {timer2Word[tsc_pkg::HOUR_LSB +: 5], timer2Word[tsc_pkg::MIN_LSB +: 6],
		timer2Word[tsc_pkg::SEC_LSB +: 6]};
	wire [6:0]  weekEn  = actDayWord[tsc_pkg::WEEKEN_LSB +: 7];
	wire [6:0]  next_timeOut;

	assign next_timeOut[tsc_pkg::TO_TIMER1]  = nowHms >= t1Hms;
	assign next_timeOut[tsc_pkg::TO_TIMER2]  = nowHms >= t2Hms;
	assign next_timeOut[tsc_pkg::TO_WEEKDAY] = weekEn[calWday];
	assign next_timeOut[tsc_pkg::TO_DAY]     = calDay == actDayWord[tsc_pkg::DAY_LSB +: 5];
	assign next_timeOut[tsc_pkg::TO_HOUR]    = calHour == actHmsWord[tsc_pkg::HOUR_LSB +: 5];
	assign next_timeOut[tsc_pkg::TO_MINUTE]  = calMin == actHmsWord[tsc_pkg::MIN_LSB +: 6];
	assign next_timeOut[tsc_pkg::TO_SECOND]  = calSec == actHmsWord[tsc_pkg::SEC_LSB +: 6];

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			evalPend  <= 1'b0;
			timeOut   <= 7'h00;
			lsFlagOut <= 5'h00;
			ledOut    <= 8'h00;
		end
		else
		begin
			// Evaluate one cycle after the calendar has settled
			evalPend <= tick || ldTime || ldDate;
			if (evalPend)
				timeOut <= next_timeOut;
			lsFlagOut <= lsFlagIn;
			ledOut    <= ledFlagIn;
		end
	end
endmodule
`default_nettype wire

//--- tsc_dummy_note_end.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

//--- tsc_top_chk.sv
`timescale 1ns/100ps
`default_nettype none
module tsc_top_chk (
	input wire logic        clk,           // Clock
	input wire logic        rst_n,         // Reset
	input wire logic        s_axi_awvalid, // AW valid
	input wire logic        s_axi_awready, // AW ready
	input wire logic [1:0]  s_axi_bresp,   // B resp
	input wire logic        s_axi_bvalid,  // B valid
	input wire logic        s_axi_bready,  // B ready
	input wire logic [7:0]  s_axi_araddr,  // AR addr
	input wire logic        s_axi_arvalid, // AR valid
	input wire logic        s_axi_arready, // AR ready
	input wire logic [31:0] s_axi_rdata,   // R data
	input wire logic [1:0]  s_axi_rresp,   // R resp
	input wire logic        s_axi_rvalid,  // R valid
	input wire logic        s_axi_rready,  // R ready
	input wire logic [4:0]  lsFlagIn,      // Share flags in
	input wire logic [7:0]  ledFlagIn,     // LED flags in
	input wire logic [4:0]  lsFlagOut,     // Share flags out
	input wire logic [7:0]  ledOut         // LED out
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	// ---------------------------------------------
	// Handshake and response steps
	// ---------------------------------------------
	sequence arTaken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence rdHeld;
		s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
	endsequence
	a_rd_answer: assert property (arTaken |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_rd_hold: assert property (s_axi_rvalid && !s_axi_rready |=> rdHeld)
		else $error("read answer dropped");
	a_rd_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	a_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_aw_held: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
		else $error("second address taken");
	a_rd_unmapped: assert property (arTaken and s_axi_araddr > 8'h1B |=>
		s_axi_rresp == tsc_pkg::RESP_DECERR && s_axi_rdata == 32'h0)
		else $error("unmapped read answer wrong");
	a_rd_mapped: assert property (arTaken and s_axi_araddr < 8'h1C |=> s_axi_rresp == tsc_pkg::RESP_OKAY)
		else $error("mapped read refused");
	a_ls_follow: assert property (lsFlagOut == $past(lsFlagIn))
		else $error("share flags not passed on");
	a_led_follow: assert property (ledOut == $past(ledFlagIn))
		else $error("LED flags not passed on");
endmodule
bind tsc_top tsc_top_chk u_chk (
	.clk(clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .lsFlagIn(lsFlagIn), .ledFlagIn(ledFlagIn),
	.lsFlagOut(lsFlagOut), .ledOut(ledOut)
);
`default_nettype wire

//--- tsc_top_tb.sv
`timescale 1ns/100ps
`default_nettype none
module tsc_top_tb;
	// Short second keeps the calendar walk brief
	localparam int TICK = 20;
	logic        clk, rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid;
	logic [7:0]  s_axi_awaddr, s_axi_araddr, ledFlagIn, ledOut;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [4:0]  lsFlagIn, lsFlagOut;
	logic [6:0]  timeOut;
	int          errTotal = 0;
	int          numChecks = 0;
	tsc_top #(.TICK_CYCLES(TICK)) uut (
		.clk(clk), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.lsFlagIn(lsFlagIn), .ledFlagIn(ledFlagIn), .timeOut(timeOut), .lsFlagOut(lsFlagOut),
		.ledOut(ledOut)
	);
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ---------------------------------------------
	// Checking and bus tasks
	// ---------------------------------------------
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		numChecks++;
		if (s !== e)
		begin
			$display("FAIL %s expected %h seen %h", nm, e, s);
			errTotal++;
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", numChecks, errTotal);
		if (errTotal == 0 && numChecks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic hang();
		errTotal++;
		final_report();
	endtask
	// Ready is looked at 1 ns after an edge, so the next edge is the handshake
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
		input logic [1:0] er);
		int n;
		logic [2:0] hs;
		logic [1:0] rsp;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			#1;
			hs = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid};
			rsp = s_axi_bresp;
			@(posedge clk);
			if (hs[2])
				s_axi_awvalid <= 1'b0;
			if (hs[1])
				s_axi_wvalid <= 1'b0;
			if (hs[0])
				break;
		end
		s_axi_bready <= 1'b0;
		if (n == 50)
			hang();
		chk("bresp", {30'h0, er}, {30'h0, rsp});
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
		int n;
		logic [1:0] hs;
		logic [1:0] rsp;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 50; n++)
		begin
			#1;
			hs = {s_axi_arvalid & s_axi_arready, s_axi_rvalid};
			d = s_axi_rdata;
			rsp = s_axi_rresp;
			@(posedge clk);
			if (hs[1])
				s_axi_arvalid <= 1'b0;
			if (hs[0])
				break;
		end
		s_axi_rready <= 1'b0;
		if (n == 50)
			hang();
		chk("rresp", {30'h0, er}, {30'h0, rsp});
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		axr(a, d, tsc_pkg::RESP_OKAY);
		chk("rdata", e, d);
	endtask
	task automatic wait_to(input logic [6:0] e, output int n);
		for (n = 0; n < 3 * TICK; n++)
		begin
			#1;
			if (timeOut === e)
				break;
			@(posedge clk);
		end
		if (n == 3 * TICK)
			hang();
		chk("timeOut", {25'h0, e}, {25'h0, timeOut});
	endtask
	// ---------------------------------------------
	// Scenarios
	// ---------------------------------------------
	task automatic t_reset_vals();
		rd_chk(tsc_pkg::OFS_TIMER1, 32'h0008_0000);
		rd_chk(tsc_pkg::OFS_TIMER2, 32'h0011_0000);
		rd_chk(tsc_pkg::OFS_ACT_HMS, 32'h000C_0000);
		rd_chk(tsc_pkg::OFS_ACT_DAY, 32'h0000_1F01);
		rd_chk(tsc_pkg::OFS_CAL_DATE, 32'h0001_0001);
	endtask
	task automatic t_bus_errors();
		logic [31:0] d;
		axw(8'h1C, 32'h0000_0001, 4'hF, tsc_pkg::RESP_DECERR);
		axr(8'h1C, d, tsc_pkg::RESP_DECERR);
		chk("unmapped", 32'h0, d);
		axw(tsc_pkg::OFS_TIMER1, 32'h0018_0000, 4'hF, tsc_pkg::RESP_SLVERR);
		axw(tsc_pkg::OFS_TIMER2, 32'h0000_3C00, 4'hF, tsc_pkg::RESP_SLVERR);
		axw(tsc_pkg::OFS_TIMER2, 32'h0000_003C, 4'hF, tsc_pkg::RESP_SLVERR);
		axw(tsc_pkg::OFS_ACT_DAY, 32'h0000_1F00, 4'hF, tsc_pkg::RESP_SLVERR);
		axw(tsc_pkg::OFS_TIMER1, 32'h0017_3B3B, 4'hF, tsc_pkg::RESP_OKAY);
		axw(tsc_pkg::OFS_TIMER2, 32'hFF16_FFFF, 4'h4, tsc_pkg::RESP_OKAY);
		rd_chk(tsc_pkg::OFS_TIMER2, 32'h0016_0000);
		rd_chk(tsc_pkg::OFS_TIMER1, 32'h0017_3B3B);
	endtask
	task automatic t_midnight();
		int n;
		axw(tsc_pkg::OFS_ACT_HMS, 32'h0017_3B3B, 4'hF, tsc_pkg::RESP_OKAY);
		axw(tsc_pkg::OFS_CAL_TIME, 32'h0017_3B3A, 4'hF, tsc_pkg::RESP_OKAY);
		wait_to(7'h3E, n);
		wait_to(7'h7F, n);
		wait_to(7'h04, n);
		chk("second length", TICK, n);
	endtask
	task automatic t_weekday();
		int n;
		axw(tsc_pkg::OFS_CAL_DATE, 32'h0002_001E, 4'hF, tsc_pkg::RESP_SLVERR);
		axw(tsc_pkg::OFS_CAL_DATE, 32'h0001_0506, 4'hF, tsc_pkg::RESP_OKAY);
		wait_to(7'h00, n);
		axw(tsc_pkg::OFS_ACT_DAY, 32'h0000_2006, 4'hF, tsc_pkg::RESP_OKAY);
		wait_to(7'h0C, n);
	endtask
	task automatic t_flags();
		int i;
		for (i = 0; i < 5; i++)
		begin
			@(posedge clk);
			lsFlagIn <= 5'h01 << i;
			ledFlagIn <= ~(8'h01 << i);
			@(posedge clk);
			#1;
			chk("lsFlagOut", {27'h0, 5'h01 << i}, {27'h0, lsFlagOut});
			chk("ledOut", {24'h0, ~(8'h01 << i)}, {24'h0, ledOut});
		end
		rd_chk(tsc_pkg::OFS_STATUS, 32'h00EF_100C);
		axw(tsc_pkg::OFS_STATUS, 32'hFFFF_FFFF, 4'hF, tsc_pkg::RESP_OKAY);
		rd_chk(tsc_pkg::OFS_STATUS, 32'h00EF_100C);
	endtask
	initial
	begin
		{rst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, lsFlagIn, ledFlagIn} = '0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_reset_vals();
		t_bus_errors();
		t_midnight();
		t_weekday();
		t_flags();
		final_report();
	end
endmodule
`default_nettype wire
